// [logic/tlpts_tx_port.sv]
`timescale 1ns/100ps
`include "tlpts_defs.svh"

module tlpts_tx_port #(
    parameter int DATA_W = `TLPTS_W_NARROW,
    parameter int REM_W = (DATA_W == `TLPTS_W_WIDE) ? `TLPTS_REM_W_WIDE : `TLPTS_REM_W_NARROW,
    parameter int KEEP_W = DATA_W / `TLPTS_DW_BITS
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Beat stream from user logic
    input wire logic [DATA_W-1:0] tx_payload_bus,
    input wire logic sof_n,
    input wire logic eof_n,
    input wire logic [REM_W-1:0] rem_n,
    input wire logic src_rdy_n,
    input wire logic src_dsc_n,
    output logic dst_rdy_n,
    // Framed beats toward the link layer
    input wire logic out_ready,
    output logic out_valid,
    output logic [DATA_W-1:0] out_data,
    output logic out_sof,
    output logic out_eof,
    output logic [KEEP_W-1:0] out_keep,
    output logic out_abort,
    // Framing violation seen on the user stream
    output logic proto_err
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic sof;
        logic eof;
        logic [KEEP_W-1:0] keep;
        logic abort;
    } tlpts_beat_t;

    typedef struct packed {
        tlpts_pkg::tlpts_state_t st;
        logic dst_rdy_n;
        logic a_vld;
        tlpts_beat_t a;
        logic b_vld;
        tlpts_beat_t b;
        logic proto_err;
    } tlpts_regs_t;

    localparam tlpts_regs_t RST_VAL = '{
        st: tlpts_pkg::TLPTS_IDLE,
        dst_rdy_n: 1'b1,
        a_vld: 1'b0,
        a: '0,
        b_vld: 1'b0,
        b: '0,
        proto_err: 1'b0
    };

    tlpts_regs_t q_ff;
    tlpts_regs_t nxt_q;
    tlpts_beat_t beat;
    logic push;
    logic xfer;
    logic [1:0] occ;

    tlpts_beat_if bi ();

    // ****************************************************************
    // Remainder decode
    // ****************************************************************
    assign xfer = ~src_rdy_n & ~q_ff.dst_rdy_n;
    assign bi.eof_taken = xfer & ~eof_n;

    generate
        if (DATA_W == `TLPTS_W_WIDE) begin : g_rem_wide
            assign bi.rem = rem_n[1:0];
        end else begin : g_rem_narrow
            assign bi.rem = {1'b0, rem_n[0]};
        end
    endgenerate

    tlpts_rem_decode u_rem_decode (
        .bi(bi)
    );

    // ****************************************************************
    // Framing and two-entry holding stage
    // ****************************************************************
    // Two entries let destination-ready come from a flip-flop and still keep
    // one beat per cycle: ready is offered only while the second slot is free.
    always_comb begin
        nxt_q = q_ff;
        nxt_q.proto_err = 1'b0;
        push = 1'b0;
        beat.data = tx_payload_bus;
        beat.sof = ~sof_n;
        beat.eof = ~eof_n;
        beat.keep = bi.keep[KEEP_W-1:0];
        beat.abort = 1'b0;
        if (xfer) begin
            case (q_ff.st)
                tlpts_pkg::TLPTS_IDLE: begin
                    if (!sof_n) begin
                        push = 1'b1;
                        if (!src_dsc_n) begin
                            nxt_q.proto_err = 1'b1;
                            beat.abort = 1'b1;
                            beat.eof = 1'b1;
                            nxt_q.st = eof_n ? tlpts_pkg::TLPTS_DISCARD : tlpts_pkg::TLPTS_IDLE;
                        end else begin
                            nxt_q.st = eof_n ? tlpts_pkg::TLPTS_IN_PKT : tlpts_pkg::TLPTS_IDLE;
                        end
                    end else begin
                        // A beat outside a packet has no header to belong to.
                        nxt_q.proto_err = 1'b1;
                    end
                end
                tlpts_pkg::TLPTS_IN_PKT: begin
                    if (!sof_n) begin
                        nxt_q.proto_err = 1'b1;
                    end else begin
                        push = 1'b1;
                        if (!src_dsc_n) begin
                            beat.abort = 1'b1;
                            beat.eof = 1'b1;
                        end
                        if (!eof_n) begin
                            nxt_q.st = tlpts_pkg::TLPTS_IDLE;
                        end else if (!src_dsc_n) begin
                            nxt_q.st = tlpts_pkg::TLPTS_DISCARD;
                        end
                    end
                end
                tlpts_pkg::TLPTS_DISCARD: begin
                    if (!eof_n) begin
                        nxt_q.st = tlpts_pkg::TLPTS_IDLE;
                    end
                end
                default: begin
                    nxt_q.st = tlpts_pkg::TLPTS_IDLE;
                end
            endcase
        end
        if (q_ff.a_vld && out_ready) begin
            nxt_q.a = q_ff.b;
            nxt_q.a_vld = q_ff.b_vld;
            nxt_q.b_vld = 1'b0;
        end
        if (push) begin
            if (!nxt_q.a_vld) begin
                nxt_q.a = beat;
                nxt_q.a_vld = 1'b1;
            end else begin
                nxt_q.b = beat;
                nxt_q.b_vld = 1'b1;
            end
        end
        nxt_q.dst_rdy_n = nxt_q.b_vld;
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            q_ff <= RST_VAL;
        end else begin
            q_ff <= nxt_q;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign dst_rdy_n = q_ff.dst_rdy_n;
    assign out_valid = q_ff.a_vld;
    assign out_data = q_ff.a.data;
    assign out_sof = q_ff.a.sof;
    assign out_eof = q_ff.a.eof;
    assign out_keep = q_ff.a.keep;
    assign out_abort = q_ff.a.abort;
    assign proto_err = q_ff.proto_err;

    // ****************************************************************
    // Checks
    // ****************************************************************
    assign occ = {1'b0, q_ff.a_vld} + {1'b0, q_ff.b_vld};

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    sequence s_push_no_pop;
        xfer && push && !(q_ff.a_vld && out_ready);
    endsequence

    sequence s_stall_push;
        xfer && push && q_ff.a_vld && !out_ready;
    endsequence

    bus_width_a: assert property ((DATA_W == `TLPTS_W_NARROW) || (DATA_W == `TLPTS_W_WIDE))
        else $error("payload width is neither 64 nor 128");

    data_pass_a: assert property ((xfer && push && !q_ff.a_vld)
                                  |=> out_valid && out_data == $past(tx_payload_bus))
        else $error("accepted payload not passed whole");

    beat_taken_a: assert property (s_push_no_pop |=> occ == $past(occ) + 2'h1)
        else $error("accepted beat not stored");

    no_beat_a: assert property ((!xfer && !(q_ff.a_vld && out_ready)) |=> occ == $past(occ))
        else $error("beat stored without handshake");

    ready_full_a: assert property (s_stall_push |=> dst_rdy_n ##1 (dst_rdy_n || $past(out_ready)))
        else $error("ready offered while full");

    ready_free_a: assert property ((occ == 2'h0) [*2] |-> !dst_rdy_n)
        else $error("ready withheld while empty");

    mid_keep_a: assert property ((xfer && eof_n && src_dsc_n && sof_n && !q_ff.a_vld
                                  && q_ff.st == tlpts_pkg::TLPTS_IN_PKT) |=> out_valid && (&out_keep))
        else $error("remainder applied to non-end beat");

    end_keep_a: assert property ((xfer && !eof_n && !sof_n && src_dsc_n && !q_ff.a_vld
                                  && q_ff.st == tlpts_pkg::TLPTS_IDLE)
                                 |=> out_keep[KEEP_W-1] && out_eof)
        else $error("end beat lost its top dword");

    abort_drop_a: assert property ((xfer && q_ff.st == tlpts_pkg::TLPTS_IN_PKT && sof_n
                                    && !src_dsc_n && eof_n) |=> q_ff.st == tlpts_pkg::TLPTS_DISCARD)
        else $error("discontinue without end not discarding");

endmodule // tlpts_tx_port

// [logic/tlpts_defs.svh]
`ifndef TLPTS_DEFS_SVH
`define TLPTS_DEFS_SVH

// ****************************************************************
// Constants of the transmit packet port
// ****************************************************************
`define TLPTS_W_NARROW 64
`define TLPTS_W_WIDE 128
`define TLPTS_DW_BITS 32
`define TLPTS_REM_W_NARROW 1
`define TLPTS_REM_W_WIDE 2
`define TLPTS_KEEP_ALL 4'hf
`define TLPTS_ST_IDLE 3'h1
`define TLPTS_ST_IN_PKT 3'h2
`define TLPTS_ST_DISCARD 3'h4

`endif

// [logic/tlpts_pkg.sv]
`include "tlpts_defs.svh"

package tlpts_pkg;

    // ****************************************************************
    // Framing states
    // ****************************************************************
    typedef enum logic [2:0] {
        TLPTS_IDLE = `TLPTS_ST_IDLE,
        TLPTS_IN_PKT = `TLPTS_ST_IN_PKT,
        TLPTS_DISCARD = `TLPTS_ST_DISCARD
    } tlpts_state_t;

    // Dword i is valid when i is not below the remainder code.
    function automatic logic [3:0] tlpts_keep_from_rem(input logic [1:0] rem);
        logic [3:0] k;
        k = `TLPTS_KEEP_ALL << rem;
        return k;
    endfunction

endpackage

// [logic/tlpts_beat_if.sv]
`timescale 1ns/100ps

interface tlpts_beat_if;
    logic eof_taken;
    logic [1:0] rem;
    logic [3:0] keep;
    modport src (output eof_taken, output rem, input keep);
    modport dec (input eof_taken, input rem, output keep);
endinterface

// [logic/tlpts_rem_decode.sv]
`timescale 1ns/100ps
`include "tlpts_defs.svh"

module tlpts_rem_decode (
    // Beat to decode
    tlpts_beat_if.dec bi
);

    // ****************************************************************
    // Remainder to dword enables
    // ****************************************************************
    // The code only counts on an accepted end beat; elsewhere all lanes carry data.
    always_comb begin
        bi.keep = bi.eof_taken ? tlpts_pkg::tlpts_keep_from_rem(bi.rem) : `TLPTS_KEEP_ALL;
    end

endmodule // tlpts_rem_decode

// [test/tlpts_user_src.sv]
`timescale 1ns/100ps

module tlpts_user_src #(
    parameter int DATA_W = 64,
    parameter int REM_W = 1
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Beat stream toward the port
    output logic [DATA_W-1:0] tx_payload_bus,
    output logic sof_n,
    output logic eof_n,
    output logic [REM_W-1:0] rem_n,
    output logic src_rdy_n,
    output logic src_dsc_n,
    input wire logic dst_rdy_n
);
    localparam int KW = DATA_W / 32;
    logic [DATA_W+KW+2:0] exp_q[$];

    // ****************************************************************
    // Beat driver
    // ****************************************************************
    // Idle lines carry inverted stale data so nothing passes for a held beat.
    task automatic idle();
        @(negedge core_clk);
        src_rdy_n = 1'b1;
        sof_n = 1'b1;
        eof_n = 1'b1;
        src_dsc_n = 1'b1;
        tx_payload_bus = ~tx_payload_bus;
    endtask

    task automatic beat(input logic [DATA_W-1:0] d, input logic s, input logic e,
                        input logic ds, input logic [REM_W-1:0] r, input logic keep_it);
        logic [KW-1:0] k;
        @(negedge core_clk);
        tx_payload_bus = d;
        sof_n = !s;
        eof_n = !e;
        src_dsc_n = !ds;
        rem_n = r;
        // A beat offered while reset is held is withdrawn, so the source stays idle.
        src_rdy_n = !resetn;
        do @(posedge core_clk); while (dst_rdy_n !== 1'b0 && resetn);
        k = e ? ({KW{1'b1}} << r) : {KW{1'b1}};
        if (keep_it && resetn) exp_q.push_back({d, s, e || ds, k, ds});
    endtask

    // Non-end beats carry a random remainder that the port must ignore.
    task automatic pkt(input int n, input logic [REM_W-1:0] r, input int ab);
        for (int i = 0; i < n; i++) begin
            beat(DATA_W'({4{$urandom}}), i == 0, i == n - 1 || i == ab, i == ab,
                 (i == n - 1 || i == ab) ? r : REM_W'($urandom), 1'b1);
            if (i == ab) break;
        end
    endtask

    initial begin
        tx_payload_bus = '0;
        rem_n = '0;
        src_rdy_n = 1'b1;
        sof_n = 1'b1;
        eof_n = 1'b1;
        src_dsc_n = 1'b1;
    end
endmodule // tlpts_user_src

// [test/tlpts_tx_port_bench.sv]
`timescale 1ns/100ps

module tlpts_tx_port_bench;
    localparam int DW = 64;
    localparam int KW = DW / 32;
    localparam int WDW = 128;
    localparam int WKW = WDW / 32;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic out_ready = 1'b0;
    logic stall = 1'b0;
    logic [DW-1:0] tx_payload_bus, out_data;
    logic [KW-1:0] out_keep;
    logic sof_n, eof_n, rem_n, src_rdy_n, src_dsc_n, dst_rdy_n;
    logic out_valid, out_sof, out_eof, out_abort, proto_err;
    logic [WDW-1:0] tx_payload_bus_w, out_data_w;
    logic [WKW-1:0] out_keep_w;
    logic [1:0] rem_n_w;
    logic sof_n_w, eof_n_w, src_rdy_n_w, src_dsc_n_w, dst_rdy_n_w;
    logic out_valid_w, out_sof_w, out_eof_w, out_abort_w, proto_err_w;
    int fails = 0;
    int n_tests = 0;
    int errs = 0;

    initial forever #10 core_clk = ~core_clk;

    tlpts_user_src #(.DATA_W(DW), .REM_W(1)) i_src (.core_clk(core_clk), .resetn(resetn),
        .tx_payload_bus(tx_payload_bus), .sof_n(sof_n), .eof_n(eof_n), .rem_n(rem_n),
        .src_rdy_n(src_rdy_n), .src_dsc_n(src_dsc_n), .dst_rdy_n(dst_rdy_n));

    tlpts_tx_port #(.DATA_W(DW)) i_dut (.core_clk(core_clk), .resetn(resetn),
        .tx_payload_bus(tx_payload_bus), .sof_n(sof_n), .eof_n(eof_n), .rem_n(rem_n),
        .src_rdy_n(src_rdy_n), .src_dsc_n(src_dsc_n), .dst_rdy_n(dst_rdy_n),
        .out_ready(out_ready), .out_valid(out_valid), .out_data(out_data),
        .out_sof(out_sof), .out_eof(out_eof), .out_keep(out_keep),
        .out_abort(out_abort), .proto_err(proto_err));

    // The widest link uses the 128-bit bus with a two-bit remainder.
    tlpts_user_src #(.DATA_W(WDW), .REM_W(2)) i_src_w (.core_clk(core_clk), .resetn(resetn),
        .tx_payload_bus(tx_payload_bus_w), .sof_n(sof_n_w), .eof_n(eof_n_w), .rem_n(rem_n_w),
        .src_rdy_n(src_rdy_n_w), .src_dsc_n(src_dsc_n_w), .dst_rdy_n(dst_rdy_n_w));

    tlpts_tx_port #(.DATA_W(WDW)) i_dut_w (.core_clk(core_clk), .resetn(resetn),
        .tx_payload_bus(tx_payload_bus_w), .sof_n(sof_n_w), .eof_n(eof_n_w), .rem_n(rem_n_w),
        .src_rdy_n(src_rdy_n_w), .src_dsc_n(src_dsc_n_w), .dst_rdy_n(dst_rdy_n_w),
        .out_ready(out_ready), .out_valid(out_valid_w), .out_data(out_data_w),
        .out_sof(out_sof_w), .out_eof(out_eof_w), .out_keep(out_keep_w),
        .out_abort(out_abort_w), .proto_err(proto_err_w));

    // ****************************************************************
    // Checking
    // ****************************************************************
    task automatic check(input logic [WDW+WKW+2:0] seen, input logic [WDW+WKW+2:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    always @(negedge core_clk) out_ready <= !stall && ($urandom % 4 != 0);

    always @(posedge core_clk) begin
        if (resetn && (proto_err === 1'b1 || proto_err_w === 1'b1)) errs++;
        if (resetn && out_valid_w === 1'b1 && out_ready) begin
            if (i_src_w.exp_q.size() == 0) check(1, 0);
            else check({out_data_w, out_sof_w, out_eof_w, out_keep_w, out_abort_w},
                       i_src_w.exp_q.pop_front());
        end
        if (resetn && out_valid === 1'b1 && out_ready) begin
            if (i_src.exp_q.size() == 0) check(1, 0);
            else check({out_data, out_sof, out_eof, out_keep, out_abort},
                       i_src.exp_q.pop_front());
        end
    end

    initial begin
        #200000;
        fails++;
        results();
    end

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        void'($urandom(60));
        repeat (5) @(posedge core_clk);
        @(negedge core_clk) resetn = 1'b1;
        for (int n = 1; n <= 4; n++)
            for (int r = 0; r < 2; r++) i_src.pkt(n, 1'(r), 99);
        i_src.pkt(4, 1'b0, 1);
        // With the far side stalled the two held beats must close the port.
        stall = 1'b1;
        i_src.idle();
        fork
            i_src.pkt(4, 1'b1, 99);
            begin
                repeat (8) @(posedge core_clk);
                #1 check(dst_rdy_n, 1'b1);
                stall = 1'b0;
            end
        join
        i_src.idle();
        // Discontinue without an end cuts the packet; beats up to the next end are dropped.
        i_src.beat(DW'({2{$urandom}}), 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
        i_src.beat(DW'({2{$urandom}}), 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
        i_src.beat(DW'({2{$urandom}}), 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        i_src.beat(DW'({2{$urandom}}), 1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
        i_src.idle();
        // A middle beat with no packet open is dropped and flagged once.
        i_src.beat(DW'(64'h0123_4567_89ab_cdef), 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        i_src.idle();
        repeat (4) @(posedge core_clk);
        check(errs, 1);
        fork
            i_src.pkt(6, 1'b0, 99);
            begin
                repeat (3) @(negedge core_clk);
                resetn = 1'b0;
            end
        join
        i_src.idle();
        i_src.exp_q.delete();
        i_src_w.exp_q.delete();
        repeat (2) @(posedge core_clk);
        #1 check({dst_rdy_n, out_valid, dst_rdy_n_w, out_valid_w}, 4'ha);
        @(negedge core_clk) resetn = 1'b1;
        i_src.pkt(3, 1'b1, 99);
        i_src.idle();
        for (int r = 0; r < 4; r++)
            i_src_w.pkt(2, 2'(r), 99);
        i_src_w.pkt(3, 2'h2, 1);
        i_src_w.idle();
        for (int i = 0; i < 200 && i_src.exp_q.size() + i_src_w.exp_q.size() != 0; i++)
            @(posedge core_clk);
        check(i_src.exp_q.size() + i_src_w.exp_q.size(), 0);
        check(errs, 1);
        results();
    end
endmodule // tlpts_tx_port_bench
